// ===== inc/pmwc_pkg.sv
package pmwc_pkg;
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned WAKE_IDLE_US  = 14;
    localparam int unsigned WAKE_STBY_US  = 151;
    localparam int unsigned WAKE_SHUT_US  = 1015;
    localparam int unsigned WAKE_IDLE_CYC = WAKE_IDLE_US * CLK_MHZ;
    localparam int unsigned WAKE_STBY_CYC = WAKE_STBY_US * CLK_MHZ;
    localparam int unsigned WAKE_SHUT_CYC = WAKE_SHUT_US * CLK_MHZ;
    localparam int unsigned BOD_PERIOD    = 64;
    localparam int unsigned N_IO          = 31;
    // register word offsets (byte addresses)
    localparam logic [4:0] REG_MODE     = 5'h00;
    localparam logic [4:0] REG_STATUS   = 5'h04;
    localparam logic [4:0] REG_RETAIN   = 5'h08;
    localparam logic [4:0] REG_CLKCFG   = 5'h0C;
    localparam logic [4:0] REG_WAKECFG  = 5'h10;
    localparam logic [4:0] REG_RSTCAUSE = 5'h14;
    localparam logic [4:0] REG_RTC_CMP0 = 5'h18;
    // field positions and register reset values
    localparam int unsigned CLK_CACHE_OFF = 0;
    localparam int unsigned CLK_SLOW_XTAL = 1;
    localparam int unsigned CLK_OUT_EN    = 2;
    localparam int unsigned WK_RTC_EN     = 0;
    localparam int unsigned WK_SC_EN      = 1;
    localparam logic [3:0]  RETAIN_RST    = 4'hF;
    localparam logic [2:0]  CLKCFG_RST    = 3'h0;
    localparam logic [1:0]  WAKECFG_RST   = 2'h3;
    typedef enum logic [1:0] {
        PMWC_REQ_NONE  = 2'h0,
        PMWC_REQ_IDLE  = 2'h1,
        PMWC_REQ_STBY  = 2'h2,
        PMWC_REQ_SHUT  = 2'h3
    } pmwc_req_t;
    // gray along active->idle->wake and active->standby->wake
    typedef enum logic [2:0] {
        PMWC_ACTIVE  = 3'h0,
        PMWC_IDLE    = 3'h1,
        PMWC_WAKE    = 3'h3,
        PMWC_STANDBY = 3'h2,
        PMWC_SHUTDN  = 3'h6,
        PMWC_RSTHELD = 3'h7
    } pmwc_state_t;
    typedef enum logic [1:0] {
        PMWC_CAUSE_POR   = 2'h0,
        PMWC_CAUSE_PIN   = 2'h1,
        PMWC_CAUSE_WAKE  = 2'h2
    } pmwc_cause_t;
    typedef struct packed {
        logic       cpu_clk_en;
        logic       mem_clk_en;
        logic       periph_clk_en;
        logic       flash_on;
        logic       radio_on;
        logic       fast_clk_en;
        logic       slow_clk_en;
        logic       aon_on;
        logic       sensor_on;
        logic [3:0] sram_on;
        logic       io_latch;
        logic       bod_en;
        logic       por_en;
    } pmwc_gate_t;
endpackage

// ===== hdl/pmwc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module pmwc_ctrl (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic [4:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic                 irq_any,
    input  wire logic                 reset_pin_n,
    input  wire logic                 por_event,
    input  wire logic [30:0]          io_in,
    input  wire logic [30:0]          io_wake_en,
    input  wire logic                 rtc_event,
    input  wire logic                 sc_wake,
    input  wire logic                 fast_crystal_osc,
    input  wire logic                 slow_crystal_osc,
    input  wire logic                 slow_rc_osc,
    output logic                      clk48_en,
    output logic                      slow_clk_sel,
    output logic                      slow_clk_out_en,
    output logic                      cache_as_ram,
    output logic                      brownout_detector,
    output logic                      cpu_resume,
    output logic                      sys_reset,
    output logic      [30:0]          io_hold_val,
    output pmwc_pkg::pmwc_gate_t      gate
);
    // pin inputs, two-flop synchronised
    logic [30:0] io_s1, io_s2, io_prev;
    logic [1:0]  rpin_s, rtc_s, sc_s, irq_s;
    logic [2:0]  osc_s1, osc_s2;
    always_ff @(posedge ref_clk) begin
        io_s1  <= io_in;
        io_s2  <= io_s1;
        osc_s1 <= {fast_crystal_osc, slow_crystal_osc, slow_rc_osc};
        osc_s2 <= osc_s1;
        rpin_s <= {rpin_s[0], ~reset_pin_n};
        rtc_s  <= {rtc_s[0], rtc_event};
        sc_s   <= {sc_s[0], sc_wake};
        irq_s  <= {irq_s[0], irq_any};
    end
    always_ff @(posedge ref_clk) begin
        io_prev <= io_s2;
    end

    pmwc_pkg::pmwc_state_t state;
    pmwc_pkg::pmwc_state_t next_state;
    pmwc_pkg::pmwc_state_t wake_from;
    logic [3:0]  retain;
    logic [2:0]  clkcfg;
    logic [1:0]  wakecfg;
    logic [1:0]  cause;
    logic [16:0] wake_cnt;
    logic [6:0]  bod_cnt;
    logic        req_pend;
    pmwc_pkg::pmwc_req_t req;

    wire logic pin_wake = |((io_s2 ^ io_prev) & io_wake_en);
    wire logic rpin     = rpin_s[1];
    wire logic rtc_wk   = rtc_s[1] & wakecfg[pmwc_pkg::WK_RTC_EN];
    wire logic sc_wk    = sc_s[1] & wakecfg[pmwc_pkg::WK_SC_EN];
    wire logic wr       = avs_write;
    wire logic fast_ok  = osc_s2[2];
    wire logic xtal_ok  = osc_s2[1];
    wire logic rc_ok    = osc_s2[0];
    wire logic count_done = (wake_cnt == 17'h00000);

    function automatic logic [16:0] wake_len(input pmwc_pkg::pmwc_state_t s);
        case (s)
            pmwc_pkg::PMWC_IDLE:    wake_len = 17'(pmwc_pkg::WAKE_IDLE_CYC - 1);
            pmwc_pkg::PMWC_STANDBY: wake_len = 17'(pmwc_pkg::WAKE_STBY_CYC - 1);
            default:                wake_len = 17'(pmwc_pkg::WAKE_SHUT_CYC - 1);
        endcase
    endfunction

    // writes take no wait; a read waits one cycle so its registered data stands
    logic rd_done;
    always_ff @(posedge ref_clk) begin
        if (rst)
            rd_done <= 1'b0;
        else
            rd_done <= avs_read && !rd_done;
    end
    assign avs_waitrequest = avs_read && !rd_done;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_pend <= 1'b0;
            req      <= pmwc_pkg::PMWC_REQ_NONE;
        end else if (wr && avs_address == pmwc_pkg::REG_MODE && avs_byteenable[0]) begin
            req_pend <= avs_writedata[1:0] != 2'h0;
            req      <= pmwc_pkg::pmwc_req_t'(avs_writedata[1:0]);
        end else if (state == pmwc_pkg::PMWC_ACTIVE) begin
            req_pend <= 1'b0;
        end
    end

    // config resets on shutdown-wake as well
    always_ff @(posedge ref_clk) begin
        if (rst || sys_reset) begin
            retain  <= pmwc_pkg::RETAIN_RST;
            clkcfg  <= pmwc_pkg::CLKCFG_RST;
            wakecfg <= pmwc_pkg::WAKECFG_RST;
        end else if (wr && avs_byteenable[0]) begin
            case (avs_address)
                pmwc_pkg::REG_RETAIN:  retain  <= avs_writedata[3:0];
                pmwc_pkg::REG_CLKCFG:  clkcfg  <= avs_writedata[2:0];
                pmwc_pkg::REG_WAKECFG: wakecfg <= avs_writedata[1:0];
                default: ;
            endcase
        end
    end

    // cause register survives the wake it records
    always_ff @(posedge ref_clk) begin
        if (rst || por_event)
            cause <= pmwc_pkg::PMWC_CAUSE_POR;
        else if (state == pmwc_pkg::PMWC_RSTHELD)
            cause <= pmwc_pkg::PMWC_CAUSE_PIN;
        else if (state == pmwc_pkg::PMWC_SHUTDN && pin_wake)
            cause <= pmwc_pkg::PMWC_CAUSE_WAKE;
    end

    always_comb begin
        next_state = state;
        case (state)
            pmwc_pkg::PMWC_ACTIVE:
                if (req_pend) begin
                    case (req)
                        pmwc_pkg::PMWC_REQ_IDLE: next_state = pmwc_pkg::PMWC_IDLE;
                        pmwc_pkg::PMWC_REQ_STBY: next_state = pmwc_pkg::PMWC_STANDBY;
                        pmwc_pkg::PMWC_REQ_SHUT: next_state = pmwc_pkg::PMWC_SHUTDN;
                        default: ;
                    endcase
                end
            pmwc_pkg::PMWC_IDLE:
                if (irq_s[1] || pin_wake || rtc_wk || sc_wk)
                    next_state = pmwc_pkg::PMWC_WAKE;
            pmwc_pkg::PMWC_STANDBY:
                if (pin_wake || rtc_wk || sc_wk)
                    next_state = pmwc_pkg::PMWC_WAKE;
            pmwc_pkg::PMWC_SHUTDN:
                if (pin_wake)
                    next_state = pmwc_pkg::PMWC_WAKE;
            pmwc_pkg::PMWC_WAKE:
                if (count_done)
                    next_state = pmwc_pkg::PMWC_ACTIVE;
            pmwc_pkg::PMWC_RSTHELD:
                if (!rpin)
                    next_state = pmwc_pkg::PMWC_WAKE;
            default: next_state = pmwc_pkg::PMWC_ACTIVE;
        endcase
        if (rpin)
            next_state = pmwc_pkg::PMWC_RSTHELD;
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            state <= pmwc_pkg::PMWC_ACTIVE;
        else
            state <= next_state;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wake_from <= pmwc_pkg::PMWC_ACTIVE;
            wake_cnt  <= 17'h00000;
        end else if (next_state == pmwc_pkg::PMWC_WAKE && state != pmwc_pkg::PMWC_WAKE) begin
            wake_from <= state;
            wake_cnt  <= wake_len(state);
        end else if (!count_done) begin
            wake_cnt  <= wake_cnt - 17'h00001;
        end
    end

    // io latch value captured on entry to standby/shutdown
    always_ff @(posedge ref_clk) begin
        if (rst)
            io_hold_val <= 31'h00000000;
        else if (state == pmwc_pkg::PMWC_ACTIVE && next_state != pmwc_pkg::PMWC_ACTIVE
                 && next_state != pmwc_pkg::PMWC_IDLE)
            io_hold_val <= io_s2;
    end

    wire logic low = state == pmwc_pkg::PMWC_STANDBY;
    wire logic off = state == pmwc_pkg::PMWC_SHUTDN || state == pmwc_pkg::PMWC_RSTHELD;
    wire logic wk_shut = state == pmwc_pkg::PMWC_WAKE && (wake_from == pmwc_pkg::PMWC_SHUTDN
                         || wake_from == pmwc_pkg::PMWC_RSTHELD);

    always_ff @(posedge ref_clk) begin
        if (rst)
            bod_cnt <= 7'h00;
        else
            bod_cnt <= (bod_cnt == 7'(pmwc_pkg::BOD_PERIOD - 1)) ? 7'h00 : bod_cnt + 7'h01;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gate              <= '0;
            brownout_detector <= 1'b0;
            sys_reset         <= 1'b1;
            cpu_resume        <= 1'b0;
            clk48_en          <= 1'b0;
            slow_clk_sel      <= 1'b0;
            slow_clk_out_en   <= 1'b0;
            cache_as_ram      <= 1'b0;
        end else begin
            gate.cpu_clk_en    <= state == pmwc_pkg::PMWC_ACTIVE;
            gate.mem_clk_en    <= state == pmwc_pkg::PMWC_ACTIVE;
            gate.periph_clk_en <= !low && !off;
            gate.flash_on      <= !low && !off;
            gate.radio_on      <= !low && !off;
            gate.fast_clk_en   <= !low && !off;
            gate.slow_clk_en   <= !off;
            gate.aon_on        <= !off;
            gate.sensor_on     <= !off;
            gate.sram_on       <= off ? 4'h0 : (low ? retain : 4'hF);
            gate.io_latch      <= low || off;
            gate.bod_en        <= !off;
            gate.por_en        <= 1'b1;
            brownout_detector  <= off ? 1'b0 : (low ? bod_cnt == 7'h00 : 1'b1);
            sys_reset          <= off || wk_shut;
            cpu_resume         <= state == pmwc_pkg::PMWC_WAKE && count_done
                                  && !wk_shut;
            clk48_en           <= fast_ok && !low && !off;
            slow_clk_sel       <= clkcfg[pmwc_pkg::CLK_SLOW_XTAL] && xtal_ok;
            slow_clk_out_en    <= clkcfg[pmwc_pkg::CLK_OUT_EN] && !off
                                  && (rc_ok || xtal_ok);
            cache_as_ram       <= clkcfg[pmwc_pkg::CLK_CACHE_OFF];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            avs_readdata <= 32'h00000000;
        else if (avs_read && !rd_done) begin
            case (avs_address)
                pmwc_pkg::REG_MODE:     avs_readdata <= {30'h0, req};
                pmwc_pkg::REG_STATUS:   avs_readdata <= {29'h0, state};
                pmwc_pkg::REG_RETAIN:   avs_readdata <= {28'h0, retain};
                pmwc_pkg::REG_CLKCFG:   avs_readdata <= {29'h0, clkcfg};
                pmwc_pkg::REG_WAKECFG:  avs_readdata <= {30'h0, wakecfg};
                pmwc_pkg::REG_RSTCAUSE: avs_readdata <= {30'h0, cause};
                default:                avs_readdata <= 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== bench/pmwc_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module pmwc_ctrl_assertions (
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire logic [4:0]           avs_address,
    input wire logic                 avs_write,
    input wire logic [31:0]          avs_writedata,
    input wire logic [3:0]           avs_byteenable,
    input wire logic                 irq_any,
    input wire logic                 reset_pin_n,
    input wire logic                 brownout_detector,
    input wire logic                 cpu_resume,
    input wire logic                 sys_reset,
    input wire logic [30:0]          io_hold_val,
    input wire pmwc_pkg::pmwc_gate_t gate
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // outputs only reflect a state one edge after release
    logic up;
    always_ff @(posedge ref_clk) begin
        up <= !rst;
    end
    sequence idle_req;
        avs_write && avs_byteenable[0] && avs_address == pmwc_pkg::REG_MODE
            && avs_writedata[1:0] == 2'h1 && gate.cpu_clk_en;
    endsequence
    sequence bod_quiet;
        (!brownout_detector)[*8];
    endsequence
    sequence shut_power;
        !gate.sensor_on && !gate.bod_en && gate.por_en && sys_reset;
    endsequence
    sequence latch_on;
        gate.io_latch && $past(gate.io_latch);
    endsequence
    sequence bod_pulse_stby;
        $rose(brownout_detector) && !gate.fast_clk_en && gate.aon_on;
    endsequence
    // an interrupt seen in idle starts an age count that resume clears
    logic        irq_wait;
    logic [10:0] irq_age;
    always_ff @(posedge ref_clk) begin
        if (rst || cpu_resume) begin
            irq_wait <= 1'b0;
            irq_age  <= 11'h000;
        end else if (irq_wait || (irq_any && gate.periph_clk_en && !gate.cpu_clk_en)) begin
            irq_wait <= 1'b1;
            irq_age  <= (irq_age == 11'h7FF) ? irq_age : irq_age + 11'h001;
        end
    end
    chk_idle_gate: assert property (idle_req |-> ##[1:4] !gate.cpu_clk_en)
        else $error("cpu clock kept after idle request");
    chk_cpu_mem: assert property (up |-> gate.cpu_clk_en == gate.mem_clk_en)
        else $error("cpu and memory clocks disagree");
    chk_idle_wake: assert property (irq_age <= 11'h5DC)
        else $error("interrupt did not end idle in time");
    chk_resume_pulse: assert property (cpu_resume |-> !sys_reset ##1 !cpu_resume)
        else $error("resume pulse malformed");
    chk_shut_off: assert property (up && !gate.aon_on |-> shut_power)
        else $error("shutdown power set wrong");
    chk_hold_stable: assert property (latch_on |-> $stable(io_hold_val))
        else $error("latched pin levels moved");
    chk_bod_gap: assert property (bod_pulse_stby |=> bod_quiet)
        else $error("brownout sampling too dense");
    chk_reset_pin: assert property ($fell(reset_pin_n) |-> ##[1:5] sys_reset)
        else $error("reset pin ignored");
endmodule
bind pmwc_ctrl pmwc_ctrl_assertions chk_u (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .irq_any(irq_any), .reset_pin_n(reset_pin_n),
    .brownout_detector(brownout_detector), .cpu_resume(cpu_resume),
    .sys_reset(sys_reset), .io_hold_val(io_hold_val), .gate(gate));
`default_nettype wire

// ===== bench/pmwc_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module pmwc_ctrl_test;
    localparam int WI = pmwc_pkg::WAKE_IDLE_CYC;
    localparam int WS = pmwc_pkg::WAKE_STBY_CYC;
    localparam int WD = pmwc_pkg::WAKE_SHUT_CYC;
    logic        ref_clk, rst, avs_read, avs_write, irq_any, clk48_en;
    logic        reset_pin_n, rtc_event, sc_wake, por_event, avs_waitrequest;
    logic        slow_clk_sel, slow_clk_out_en, cache_as_ram, brownout_detector;
    logic        cpu_resume, sys_reset;
    logic        fast_crystal_osc, slow_crystal_osc, slow_rc_osc;
    logic [3:0]  avs_byteenable;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdv;
    logic [30:0] io_in, io_wake_en, io_hold_val;
    int          bad_count = 0, n_tests = 0, n, k;
    pmwc_pkg::pmwc_gate_t gate;
    pmwc_ctrl dut_u (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq_any, .reset_pin_n,
        .por_event, .io_in, .io_wake_en, .rtc_event, .sc_wake, .fast_crystal_osc,
        .slow_crystal_osc, .slow_rc_osc, .clk48_en, .slow_clk_sel,
        .slow_clk_out_en, .cache_as_ram, .brownout_detector, .cpu_resume, .sys_reset,
        .io_hold_val, .gate);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= b;
        avs_write <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(negedge ref_clk);
    endtask
    // read data is taken at the very edge where waitrequest is seen low
    task automatic rd(input logic [4:0] a);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_read <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge ref_clk);
    endtask
    task automatic wait_resume(input int lim);
        n = 0;
        while (cpu_resume !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        // sized for the idle, standby and shutdown wake counts together plus margin
        repeat (150000) @(posedge ref_clk);
        bad_count++;
        conclude();
    end
    initial begin
        {rst, avs_read, avs_write, irq_any, rtc_event, sc_wake, por_event} = 7'h40;
        reset_pin_n = 1'b1;
        {fast_crystal_osc, slow_crystal_osc, slow_rc_osc} = 3'h7;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        io_in = 31'h2AAA5555;
        io_wake_en = 31'h00000001;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(2);
        rd(pmwc_pkg::REG_RSTCAUSE); `CHK("cause", pmwc_pkg::PMWC_CAUSE_POR, rdv[1:0])
        rd(pmwc_pkg::REG_WAKECFG); `CHK("wakecfg", pmwc_pkg::WAKECFG_RST, rdv[1:0])
        wr(pmwc_pkg::REG_RETAIN, 32'h0, 4'h0);
        rd(pmwc_pkg::REG_RETAIN); `CHK("retain", pmwc_pkg::RETAIN_RST, rdv[3:0])
        rd(5'h1C); `CHK("unmapped", 32'h0, rdv)
        wr(pmwc_pkg::REG_CLKCFG, 32'h7);
        cyc(2);
        `CHK("cache_ram", 1'b1, cache_as_ram)
        `CHK("slow_sel", 1'b1, slow_clk_sel)
        `CHK("clk_out", 1'b1, slow_clk_out_en)
        `CHK("clk48", 1'b1, clk48_en)
        @(posedge ref_clk);
        {fast_crystal_osc, slow_crystal_osc} <= 2'h0;
        cyc(4);
        `CHK("clk48_off", 1'b0, clk48_en)
        `CHK("slow_fallback", 1'b0, slow_clk_sel)
        `CHK("clk_out_rc", 1'b1, slow_clk_out_en)
        @(posedge ref_clk);
        {fast_crystal_osc, slow_crystal_osc} <= 2'h3;
        wr(pmwc_pkg::REG_CLKCFG, 32'h0);
        cyc(2);
        `CHK("slow_rc", 1'b0, slow_clk_sel)
        $display("test registers done");
        wr(pmwc_pkg::REG_MODE, 32'h1);
        cyc(4);
        `CHK("idle_cpu", 1'b0, gate.cpu_clk_en)
        `CHK("idle_per", 1'b1, gate.periph_clk_en)
        @(posedge ref_clk);
        irq_any <= 1'b1;
        wait_resume(2000);
        `CHK("idle_lat", 1'b1, n >= WI && n <= WI + 10)
        @(posedge ref_clk);
        irq_any <= 1'b0;
        cyc(2);
        `CHK("idle_back", 1'b1, gate.cpu_clk_en)
        $display("test idle done");
        wr(pmwc_pkg::REG_RETAIN, 32'h5);
        wr(pmwc_pkg::REG_WAKECFG, 32'h1);
        wr(pmwc_pkg::REG_MODE, 32'h2);
        cyc(4);
        `CHK("stby_sram", 4'h5, gate.sram_on)
        `CHK("stby_aon", 1'b1, gate.aon_on)
        `CHK("stby_fast", 1'b0, gate.fast_clk_en)
        @(posedge ref_clk);
        // bit 0 is the enabled wake pin, so it keeps its level here
        io_in <= 31'h5555AAAB;
        sc_wake <= 1'b1;
        k = 0;
        repeat (128) begin
            @(negedge ref_clk);
            k += int'(brownout_detector);
        end
        `CHK("bod_duty", 2, k)
        `CHK("stby_hold", 31'h2AAA5555, io_hold_val)
        `CHK("sc_masked", 1'b0, gate.fast_clk_en)
        @(posedge ref_clk);
        sc_wake <= 1'b0;
        rtc_event <= 1'b1;
        wait_resume(16000);
        `CHK("stby_lat", 1'b1, n >= WS && n <= WS + 10)
        @(posedge ref_clk);
        rtc_event <= 1'b0;
        rd(pmwc_pkg::REG_RETAIN); `CHK("stby_ret", 4'h5, rdv[3:0])
        $display("test standby done");
        wr(pmwc_pkg::REG_CLKCFG, 32'h7);
        wr(pmwc_pkg::REG_MODE, 32'h3);
        cyc(4);
        `CHK("sd_aon", 1'b0, gate.aon_on)
        `CHK("sd_por", 1'b1, gate.por_en)
        `CHK("sd_hold", 31'h5555AAAB, io_hold_val)
        @(posedge ref_clk);
        rtc_event <= 1'b1;
        cyc(50);
        `CHK("sd_rtc", 1'b0, gate.aon_on)
        @(posedge ref_clk);
        rtc_event <= 1'b0;
        io_in <= 31'h5555AAAA;
        n = 0;
        while (sys_reset !== 1'b0 && n < 110000) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK("sd_lat", 1'b1, n >= WD && n <= WD + 20)
        rd(pmwc_pkg::REG_RSTCAUSE); `CHK("sd_cause", pmwc_pkg::PMWC_CAUSE_WAKE, rdv[1:0])
        rd(pmwc_pkg::REG_CLKCFG); `CHK("sd_clk", pmwc_pkg::CLKCFG_RST, rdv[2:0])
        $display("test shutdown done");
        @(posedge ref_clk);
        reset_pin_n <= 1'b0;
        cyc(6);
        `CHK("pin_rst", 1'b1, sys_reset)
        rd(pmwc_pkg::REG_RSTCAUSE); `CHK("pin_cause", pmwc_pkg::PMWC_CAUSE_PIN, rdv[1:0])
        $display("test reset pin done");
        conclude();
    end
endmodule
`default_nettype wire
